/* verilog/tsmg_pkg.sv */
package tsmg_pkg;

  // Register byte addresses
  localparam logic [7:0] TSMG_ADDR_WAVE = 8'h00;
  localparam logic [7:0] TSMG_ADDR_OCTAVE_HALVE_BIT = 8'h04;
  localparam logic [7:0] TSMG_ADDR_SATT = 8'h08;
  localparam logic [7:0] TSMG_ADDR_DC = 8'h0C;
  localparam logic [7:0] TSMG_ADDR_PULSE = 8'h10;
  localparam logic [7:0] TSMG_ADDR_STAT = 8'h14;

  // Field positions
  localparam int TSMG_WAVE_MODE_LSB = 0;
  localparam int TSMG_WAVE_RANGE_LSB = 2;
  localparam int TSMG_OCTAVE_HALVE_BIT_MUL_LSB = 0;
  localparam int TSMG_OCTAVE_HALVE_BIT_DIV_LSB = 8;
  localparam int TSMG_OCTAVE_HALVE_BIT_OCT_BIT = 16;
  localparam int TSMG_PULSE_FIRST_LSB = 0;
  localparam int TSMG_PULSE_SECOND_LSB = 8;
  localparam int TSMG_STAT_ALIGN_BIT = 16;
  localparam int TSMG_STAT_SWITCH_BIT = 17;

  // Reset values
  localparam logic [2:0] TSMG_RST_RANGE = 3'h0;
  localparam logic [3:0] TSMG_RST_MUL = 4'h0;
  localparam logic [7:0] TSMG_RST_DIV = 8'h00;
  localparam logic TSMG_RST_OCT = 1'b0;
  localparam logic [7:0] TSMG_RST_SATT = 8'h00;
  localparam logic [23:0] TSMG_RST_DC = 24'h000000;
  localparam logic [4:0] TSMG_RST_PULSE = 5'h00;

  // Sine timing: base frequency is master clock over a fixed step count
  localparam int TSMG_SINE_BASE_HZ = 250;
  localparam int TSMG_MCLK_NOM_HZ = 4096000;
  localparam int TSMG_SINE_STEPS = TSMG_MCLK_NOM_HZ / TSMG_SINE_BASE_HZ;
  localparam int TSMG_PHASE_W = $clog2(TSMG_SINE_STEPS);

  // Attenuation constants
  localparam logic [2:0] TSMG_RANGE_MAX = 3'h6;
  localparam logic [3:0] TSMG_MUTE_NIBBLE = 4'hF;
  localparam logic [7:0] TSMG_ATT_PER_HALVING = 8'h0C;
  localparam logic [15:0] TSMG_ATT_FRAC [12] = '{
    16'hFFFF, 16'hF1B1, 16'hE42C, 16'hD766, 16'hCB59, 16'hBFF9,
    16'hB53B, 16'hAB16, 16'hA189, 16'h9880, 16'h8FF3, 16'h87E9};

  // Pulse codes
  localparam logic [4:0] TSMG_PULSE_UNUSED = 5'h10;
  localparam logic [4:0] TSMG_PULSE_ZERO = 5'h00;

  typedef enum logic [1:0] {
    TSMG_MODE_SINE = 2'b00,
    TSMG_MODE_DC = 2'b01,
    TSMG_MODE_BITS = 2'b10,
    TSMG_MODE_PULSE = 2'b11
  } tsmg_mode_e;

  typedef struct packed {
    tsmg_mode_e mode;
    logic [2:0] range;
    logic [3:0] mul;
    logic [7:0] div;
    logic octave;
    logic [7:0] satt;
    logic [23:0] dc;
    logic [4:0] pfirst;
    logic [4:0] psecond;
  } tsmg_cfg_s;

endpackage

/* verilog/tsmg_sine_shape.sv */
`timescale 1ns/1ps
`default_nettype none
module tsmg_sine_shape
  import tsmg_pkg::*;
(
  input wire logic [TSMG_PHASE_W-1:0] phase_i,
  output logic signed [23:0] wave_o
);

  // Parabolic half-wave; cheap, no table, a few percent shape error
  localparam int HW = TSMG_PHASE_W - 1;
  localparam logic [HW:0] HALF = {1'b1, {HW{1'b0}}};

  logic [HW-1:0] h;
  logic [HW:0] rest;
  logic [2*HW:0] prod;
  logic [23:0] mag;

  always_comb
  begin
    h = phase_i[HW-1:0];
    rest = HALF - {1'b0, h};
    prod = {1'b0, h} * rest;
    mag = (prod[2*HW:1] > {{(2*HW-23){1'b0}}, 23'h7FFFFF}) ?
          24'h7FFFFF : prod[24:1];
    wave_o = phase_i[HW] ? -$signed(mag) : $signed(mag);
  end

endmodule // tsmg_sine_shape
`default_nettype wire

/* verilog/tsmg_atten.sv */
`timescale 1ns/1ps
`default_nettype none
module tsmg_atten
  import tsmg_pkg::*;
(
  input wire logic signed [23:0] wave_i,
  input wire logic [7:0] code_i,
  output logic signed [23:0] wave_o
);

  // Twelve half-dB counts make one halving; the 0.02 dB drift is accepted
  logic [7:0] halvings;
  logic [7:0] rem;
  logic signed [40:0] prod;
  logic signed [40:0] shifted;

  always_comb
  begin
    halvings = code_i / TSMG_ATT_PER_HALVING;
    rem = code_i - 8'(halvings * TSMG_ATT_PER_HALVING);
    prod = wave_i * $signed({1'b0, TSMG_ATT_FRAC[rem[3:0]]});
    shifted = prod >>> (16 + halvings);
    if (code_i[7:4] == TSMG_MUTE_NIBBLE)
    begin
      wave_o = 24'sh000000;
    end
    else
    begin
      wave_o = shifted[23:0];
    end
  end

endmodule // tsmg_atten
`default_nettype wire

/* verilog/tsmg_core.sv */
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
module tsmg_core
  import tsmg_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic time_align_i,
  input wire logic switch_or_bitstream_input_i,
  output logic [1:0] mode_o,
  output logic signed [23:0] sample_o,
  output logic [2:0] range_select_o,
  output logic bitstream_bit_o,
  output logic [4:0] pulse_code_o,
  output logic switch_enable_o
);

  tsmg_cfg_s cfg_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic req;
  logic wr_take;
  logic [31:0] wmask;
  logic octave_halve_bit_restart;

  logic [1:0] align_sync_q;
  logic [1:0] swbit_sync_q;
  logic align_prev_q;
  logic align_rise;

  logic [7:0] frac_q;
  logic [8:0] frac_sum;
  logic frac_carry;
  logic [TSMG_PHASE_W:0] phase_q;
  logic [TSMG_PHASE_W-1:0] sine_phase;
  logic signed [23:0] raw_wave;
  logic signed [23:0] att_wave;

  logic [4:0] pulse_pick;
  logic signed [23:0] sample_d;

  // Bus handshake: one wait cycle, answer on the second edge
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_take = avs_write_i & ack_q;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      wmask[8*i +: 8] = {8{avs_byteenable_i[i]}};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= req & ~ack_q;
    end
  end

  // Register writes, lane by lane
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cfg_q.mode <= TSMG_MODE_SINE;
      cfg_q.range <= TSMG_RST_RANGE;
      cfg_q.mul <= TSMG_RST_MUL;
      cfg_q.div <= TSMG_RST_DIV;
      cfg_q.octave <= TSMG_RST_OCT;
      cfg_q.satt <= TSMG_RST_SATT;
      cfg_q.dc <= TSMG_RST_DC;
      cfg_q.pfirst <= TSMG_RST_PULSE;
      cfg_q.psecond <= TSMG_RST_PULSE;
    end
    else if (wr_take)
    begin
      unique case (avs_address_i)
        TSMG_ADDR_WAVE:
        begin
          if (avs_byteenable_i[0])
          begin
            cfg_q.mode <= tsmg_mode_e'(
              avs_writedata_i[TSMG_WAVE_MODE_LSB +: 2]);
            cfg_q.range <= avs_writedata_i[TSMG_WAVE_RANGE_LSB +: 3];
          end
        end
        TSMG_ADDR_OCTAVE_HALVE_BIT:
        begin
          if (avs_byteenable_i[0])
          begin
            cfg_q.mul <= avs_writedata_i[TSMG_OCTAVE_HALVE_BIT_MUL_LSB +: 4];
          end
          if (avs_byteenable_i[1])
          begin
            cfg_q.div <= avs_writedata_i[TSMG_OCTAVE_HALVE_BIT_DIV_LSB +: 8];
          end
          if (avs_byteenable_i[2])
          begin
            cfg_q.octave <= avs_writedata_i[TSMG_OCTAVE_HALVE_BIT_OCT_BIT];
          end
        end
        TSMG_ADDR_SATT:
        begin
          if (avs_byteenable_i[0])
          begin
            cfg_q.satt <= avs_writedata_i[7:0];
          end
        end
        TSMG_ADDR_DC:
        begin
          cfg_q.dc <= (cfg_q.dc & ~wmask[23:0]) |
                      (avs_writedata_i[23:0] & wmask[23:0]);
        end
        TSMG_ADDR_PULSE:
        begin
          if (avs_byteenable_i[0])
          begin
            cfg_q.pfirst <= avs_writedata_i[TSMG_PULSE_FIRST_LSB +: 5];
          end
          if (avs_byteenable_i[1])
          begin
            cfg_q.psecond <= avs_writedata_i[TSMG_PULSE_SECOND_LSB +: 5];
          end
        end
        default:
        begin
          // Unmapped and read-only words ignore writes
        end
      endcase
    end
  end

  // Read data captured during the wait cycle, stands in the answer cycle
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      rdata_q <= 32'h00000000;
    end
    else if (avs_read_i & ~ack_q)
    begin
      rdata_q <= 32'h00000000;
      unique case (avs_address_i)
        TSMG_ADDR_WAVE:
        begin
          rdata_q[TSMG_WAVE_MODE_LSB +: 2] <= cfg_q.mode;
          rdata_q[TSMG_WAVE_RANGE_LSB +: 3] <= cfg_q.range;
        end
        TSMG_ADDR_OCTAVE_HALVE_BIT:
        begin
          rdata_q[TSMG_OCTAVE_HALVE_BIT_MUL_LSB +: 4] <= cfg_q.mul;
          rdata_q[TSMG_OCTAVE_HALVE_BIT_DIV_LSB +: 8] <= cfg_q.div;
          rdata_q[TSMG_OCTAVE_HALVE_BIT_OCT_BIT] <= cfg_q.octave;
        end
        TSMG_ADDR_SATT:
        begin
          rdata_q[7:0] <= cfg_q.satt;
        end
        TSMG_ADDR_DC:
        begin
          rdata_q[23:0] <= cfg_q.dc;
        end
        TSMG_ADDR_PULSE:
        begin
          rdata_q[TSMG_PULSE_FIRST_LSB +: 5] <= cfg_q.pfirst;
          rdata_q[TSMG_PULSE_SECOND_LSB +: 5] <= cfg_q.psecond;
        end
        TSMG_ADDR_STAT:
        begin
          rdata_q[TSMG_PHASE_W:0] <= phase_q;
          rdata_q[TSMG_STAT_ALIGN_BIT] <= align_sync_q[1];
          rdata_q[TSMG_STAT_SWITCH_BIT] <= swbit_sync_q[1];
        end
        default:
        begin
          // Unmapped words read as zero
        end
      endcase
    end
  end

  assign avs_readdata_o = rdata_q;

  // Pins are asynchronous to the core clock
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      align_sync_q <= 2'b00;
      swbit_sync_q <= 2'b00;
      align_prev_q <= 1'b0;
    end
    else
    begin
      align_sync_q <= {align_sync_q[0], time_align_i};
      swbit_sync_q <= {swbit_sync_q[0], switch_or_bitstream_input_i};
      align_prev_q <= align_sync_q[1];
    end
  end

  assign align_rise = align_sync_q[1] & ~align_prev_q;

  // Multiplier or divider lane written restarts the wave
  assign octave_halve_bit_restart = wr_take & (avs_address_i == TSMG_ADDR_OCTAVE_HALVE_BIT) &
                        (avs_byteenable_i[0] | avs_byteenable_i[1]);

  // Fractional step: M+1 parts of N+1 per clock; host keeps M <= N so
  // at most one phase step per clock
  always_comb
  begin
    frac_sum = {1'b0, frac_q} + {5'h00, cfg_q.mul} + 9'h001;
    frac_carry = frac_sum > {1'b0, cfg_q.div};
  end

  // Phase advances once per N+1 master clock parts, so rate tracks clock
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      frac_q <= 8'h00;
      phase_q <= '0;
    end
    else if (octave_halve_bit_restart)
    begin
      frac_q <= 8'h00;
      phase_q <= '0;
    end
    else if ((cfg_q.mode == TSMG_MODE_SINE) && align_rise)
    begin
      frac_q <= 8'h00;
      phase_q <= '0;
    end
    else if (frac_carry)
    begin
      frac_q <= 8'(frac_sum - {1'b0, cfg_q.div} - 9'h001);
      phase_q <= phase_q + 1'b1;
    end
    else
    begin
      frac_q <= frac_sum[7:0];
    end
  end

  // Octave bit doubles the period by dropping the lowest phase bit
  assign sine_phase = cfg_q.octave ? phase_q[TSMG_PHASE_W:1] :
                      phase_q[TSMG_PHASE_W-1:0];

  tsmg_sine_shape u_shape (
    .phase_i(sine_phase),
    .wave_o(raw_wave)
  );

  tsmg_atten u_atten (
    .wave_i(raw_wave),
    .code_i(cfg_q.satt),
    .wave_o(att_wave)
  );

  // Pulse level pick; the unused code maps to zero
  always_comb
  begin
    pulse_pick = align_sync_q[1] ? cfg_q.psecond : cfg_q.pfirst;
    if (pulse_pick == TSMG_PULSE_UNUSED)
    begin
      pulse_pick = TSMG_PULSE_ZERO;
    end
  end

  always_comb
  begin
    unique case (cfg_q.mode)
      TSMG_MODE_SINE:
      begin
        sample_d = att_wave;
      end
      TSMG_MODE_DC:
      begin
        sample_d = $signed(cfg_q.dc);
      end
      TSMG_MODE_BITS:
      begin
        sample_d = 24'sh000000;
      end
      TSMG_MODE_PULSE:
      begin
        sample_d = 24'sh000000;
      end
    endcase
  end

  // Outputs from flops
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      mode_o <= TSMG_MODE_SINE;
      sample_o <= 24'sh000000;
      pulse_code_o <= TSMG_PULSE_ZERO;
    end
    else
    begin
      mode_o <= cfg_q.mode;
      sample_o <= sample_d;
      // Sign-magnitude code passed straight to the pulse converter
      pulse_code_o <= (cfg_q.mode == TSMG_MODE_PULSE) ?
                      pulse_pick : TSMG_PULSE_ZERO;
    end
  end

  // Range shift for the analog stage; pulse mode bypasses it
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      range_select_o <= TSMG_RST_RANGE;
    end
    else if (cfg_q.mode == TSMG_MODE_PULSE)
    begin
      range_select_o <= TSMG_RST_RANGE;
    end
    else if (cfg_q.range > TSMG_RANGE_MAX)
    begin
      range_select_o <= TSMG_RANGE_MAX;
    end
    else
    begin
      range_select_o <= cfg_q.range;
    end
  end

  // Shared pin: data in bitstream mode, switch gate otherwise
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      bitstream_bit_o <= 1'b0;
      switch_enable_o <= 1'b0;
    end
    else if (cfg_q.mode == TSMG_MODE_BITS)
    begin
      bitstream_bit_o <= swbit_sync_q[1];
      switch_enable_o <= 1'b0;
    end
    else
    begin
      bitstream_bit_o <= 1'b0;
      switch_enable_o <= swbit_sync_q[1];
    end
  end

endmodule // tsmg_core
`default_nettype wire

/* testbench/tsmg_props.sv */
`timescale 1ns/1ps
`default_nettype none
module tsmg_props
  import tsmg_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  input wire logic time_align_i,
  input wire logic switch_or_bitstream_input_i,
  input wire logic [1:0] mode_o,
  input wire logic signed [23:0] sample_o,
  input wire logic [2:0] range_select_o,
  input wire logic bitstream_bit_o,
  input wire logic [4:0] pulse_code_o,
  input wire logic switch_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Synchronizers hold reset values for three edges
  logic [1:0] up_q;
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      up_q <= 2'h0;
    else if (up_q != 2'h3)
      up_q <= up_q + 2'h1;
  end
  a_bits_follow: assert property (
    mode_o == 2'b10 && $past(mode_o, 3) == 2'b10 && up_q == 2'h3
    |-> bitstream_bit_o == $past(switch_or_bitstream_input_i, 3))
    else $error("bitstream output not following pin");
  a_switch_follow: assert property (
    mode_o != 2'b10 && $past(mode_o, 3) != 2'b10 && up_q == 2'h3
    |-> switch_enable_o == $past(switch_or_bitstream_input_i, 3))
    else $error("switch enable not following pin");
  a_bits_no_switch: assert property (
    mode_o == 2'b10 && $stable(mode_o) |-> !switch_enable_o)
    else $error("switch enabled in bitstream mode");
  a_pulse_quiet: assert property (
    mode_o == 2'b11 && $stable(mode_o)
    |-> sample_o == 24'sh0 && range_select_o == 3'h0)
    else $error("pulse mode carries range or sample");
  a_range_capped: assert property (
    range_select_o <= TSMG_RANGE_MAX)
    else $error("range beyond smallest");
  a_no_code_16: assert property (
    pulse_code_o != TSMG_PULSE_UNUSED)
    else $error("undefined pulse code driven");
  a_code_idle: assert property (
    mode_o != 2'b11 && $stable(mode_o) |-> pulse_code_o == 5'h00)
    else $error("pulse code outside pulse mode");
  a_octave_halve_bit_restart: assert property (
    avs_write_i && !avs_waitrequest_o && avs_address_i == TSMG_ADDR_OCTAVE_HALVE_BIT
    && (|avs_byteenable_i[1:0]) && mode_o == 2'b00 && $stable(mode_o)
    |-> ##2 sample_o == 24'sh0)
    else $error("sine not restarted by rate write");
  a_align_restart: assert property (
    $rose(time_align_i) && mode_o == 2'b00 ##1 mode_o == 2'b00 [*2]
    |-> ##2 sample_o == 24'sh0)
    else $error("sine not restarted by align");
endmodule // tsmg_props
bind tsmg_core tsmg_props u_props (.clk_i(clk_i), .srst_i(srst_i),
  .avs_address_i(avs_address_i), .avs_write_i(avs_write_i),
  .avs_byteenable_i(avs_byteenable_i),
  .avs_waitrequest_o(avs_waitrequest_o), .time_align_i(time_align_i),
  .switch_or_bitstream_input_i(switch_or_bitstream_input_i),
  .mode_o(mode_o), .sample_o(sample_o), .range_select_o(range_select_o),
  .bitstream_bit_o(bitstream_bit_o), .pulse_code_o(pulse_code_o),
  .switch_enable_o(switch_enable_o));
`default_nettype wire

/* testbench/tsmg_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module tsmg_host_model
  import tsmg_pkg::*;
(
  input wire logic clk_i,
  input wire logic waitrequest_i,
  input wire logic [31:0] readdata_i,
  output logic [7:0] address_o,
  output logic read_o,
  output logic write_o,
  output logic [31:0] writedata_o,
  output logic [3:0] byteenable_o,
  output logic time_align_o,
  output logic pin_o
);
  initial
  begin
    address_o = 8'h00;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0;
    byteenable_o = 4'hF;
    time_align_o = 1'b0;
    pin_o = 1'b0;
  end
  // Waitrequest and data taken at the rising edge; only the watchdog ends
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    address_o <= a;
    writedata_o <= d;
    write_o <= wr;
    read_o <= !wr;
    do
    begin
      @(posedge clk_i);
    end
    while (waitrequest_i !== 1'b0);
    q = readdata_i;
    write_o <= 1'b0;
    read_o <= 1'b0;
    // Released lines show garbage, not the last value
    address_o <= ~a;
    writedata_o <= ~d;
  endtask
  task automatic octave_halve_bit(input logic [3:0] m, input logic [7:0] n,
    input logic o);
    logic [31:0] q;
    if (m > n)
      m = n[3:0];
    xfer(1'b1, TSMG_ADDR_OCTAVE_HALVE_BIT, {15'h0, o, n, 4'h0, m}, q);
  endtask
  task automatic pins(input logic al, input logic sw);
    @(posedge clk_i);
    time_align_o <= al;
    pin_o <= sw;
  endtask
  // Three ones in four on average, one bit per sixteen clocks
  task automatic stream(input int bits);
    repeat (bits)
    begin
      @(posedge clk_i);
      pin_o <= ($urandom_range(0, 3) != 0);
      repeat (15) @(posedge clk_i);
    end
  endtask
endmodule // tsmg_host_model
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import tsmg_pkg::*;
;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] adr;
  logic rd, wr, wt, al, pin, bit_o, swe;
  logic [31:0] wd, rdat;
  logic [3:0] be;
  logic [1:0] mode;
  logic signed [23:0] smp;
  logic [2:0] rng;
  logic [4:0] pc;
  int errors = 0;
  int checks = 0;
  always #5 clk_i = ~clk_i;
  tsmg_core DUT (.clk_i(clk_i), .srst_i(srst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .time_align_i(al),
    .switch_or_bitstream_input_i(pin), .mode_o(mode), .sample_o(smp),
    .range_select_o(rng), .bitstream_bit_o(bit_o), .pulse_code_o(pc),
    .switch_enable_o(swe));
  tsmg_host_model host (.clk_i(clk_i), .waitrequest_i(wt),
    .readdata_i(rdat), .address_o(adr), .read_o(rd), .write_o(wr),
    .writedata_o(wd), .byteenable_o(be), .time_align_o(al), .pin_o(pin));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic w(logic [7:0] a, logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic r(logic [7:0] a, logic [31:0] e);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk("readback", e, q);
  endtask
  task automatic settle(int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask
  function automatic logic [4:0] exp_pc(logic [4:0] c);
    return (c == 5'h10) ? 5'h00 : c;
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #900000;
    errors++;
    end_sim();
  end
  initial
  begin
    logic [31:0] q;
    logic [4:0] pa;
    logic [4:0] pb;
    logic signed [23:0] prev;
    logic signed [23:0] peak;
    int per;
    int t;
    q = $urandom(32'hE39B3222);
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    // Status word excluded: the phase runs freely from reset
    for (int i = 0; i < 5; i++)
      r(8'(i * 4), 32'h0);
    w(8'h18, 32'hFFFFFFFF);
    r(8'h18, 32'h0);
    w(TSMG_ADDR_WAVE, 32'hFFFFFFFF);
    r(TSMG_ADDR_WAVE, 32'h1F);
    w(TSMG_ADDR_OCTAVE_HALVE_BIT, 32'hFFFFFFFF);
    r(TSMG_ADDR_OCTAVE_HALVE_BIT, 32'h1FF0F);
    w(TSMG_ADDR_PULSE, 32'hFFFFFFFF);
    r(TSMG_ADDR_PULSE, 32'h1F1F);
    for (int m = 0; m < 4; m++)
    begin
      w(TSMG_ADDR_WAVE, 32'(m));
      settle(2);
      chk("mode", 32'(m), {30'h0, mode});
    end
    for (int g = 0; g < 8; g++)
    begin
      w(TSMG_ADDR_WAVE, 32'((g << 2) | 1));
      settle(2);
      chk("range", (g > 6) ? 32'h6 : 32'(g), {29'h0, rng});
    end
    w(TSMG_ADDR_WAVE, 32'h17);
    settle(2);
    chk("range", 32'h0, {29'h0, rng});
    w(TSMG_ADDR_WAVE, 32'(($urandom & 7) << 2 | 1));
    for (int i = 0; i < 6; i++)
    begin
      q = (i == 0) ? 32'hC00000 : (i == 1) ? 32'h800001 : $urandom;
      w(TSMG_ADDR_DC, q);
      settle(2);
      chk("dc", {8'h0, q[23:0]}, {8'h0, smp});
    end
    w(TSMG_ADDR_WAVE, 32'h3);
    for (int i = 0; i < 8; i++)
    begin
      pa = (i == 0) ? 5'h10 : (i == 1) ? 5'h11 : 5'($urandom);
      pb = ~pa;
      w(TSMG_ADDR_PULSE, {19'h0, pb, 3'h0, pa});
      host.pins(1'b0, 1'b1);
      settle(4);
      chk("pulse", {27'h0, exp_pc(pa)}, {27'h0, pc});
      host.pins(1'b1, 1'b0);
      settle(4);
      chk("pulse", {27'h0, exp_pc(pb)}, {27'h0, pc});
    end
    w(TSMG_ADDR_WAVE, 32'h2);
    host.stream(40);
    w(TSMG_ADDR_WAVE, 32'h0);
    host.pins(1'b0, 1'b1);
    w(TSMG_ADDR_SATT, 32'($urandom_range(240, 255)));
    host.octave_halve_bit(4'h0, 8'h00, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      settle(37);
      chk("muted", 32'h0, {8'h0, smp});
    end
    // Slow rate so the phase barely moves while read back
    host.octave_halve_bit(4'h0, 8'hFF, 1'b0);
    r(TSMG_ADDR_STAT, 32'h20000);
    settle(3000);
    host.pins(1'b1, 1'b1);
    settle(4);
    host.xfer(1'b0, TSMG_ADDR_STAT, 32'h0, q);
    chk("phase", 32'h0, {17'h0, q[14:0]});
    // Full range with small digital attenuation keeps the best noise
    w(TSMG_ADDR_SATT, 32'h0C);
    for (int k = 0; k < 2; k++)
    begin
      host.octave_halve_bit(4'(k), 8'(k * 2), 1'(1 - k));
      t = (16384 * (k * 2 + 1) / (k + 1)) << (1 - k);
      settle(1);
      per = 2;
      prev = smp;
      peak = 24'sh0;
      do
      begin
        @(negedge clk_i);
        per++;
        if (smp > peak)
          peak = smp;
        if (prev < 0 && smp >= 0)
          break;
        prev = smp;
      end
      while (per < 70000);
      chk("period", 32'h1, 32'(per >= t - 4 && per <= t + 4));
      chk("peak", 32'h1, 32'(peak > 24'sh3F0000 && peak <= 24'sh400000));
    end
    end_sim();
  end
endmodule // testbench
`default_nettype wire
